// File: t1ja_cfg.svh
// constants for the t1/j1 receive alarm detector
`ifndef T1JA_CFG_SVH
`define T1JA_CFG_SVH
// ==========================================
// register indices, byte address is four times
`define T1JA_IX_STAT 8'hB9
`define T1JA_IX_IEN 8'hBA
`define T1JA_IX_CHG 8'hBB
`define T1JA_IX_RDTH 8'hBC
`define T1JA_IX_RCTH 8'hBD
`define T1JA_IX_YDTH 8'hBE
`define T1JA_IX_YCTH 8'hBF
`define T1JA_IX_ADTH 8'hC0
`define T1JA_IX_ACTH 8'hC1
`define T1JA_IX_FMT 8'hC8
// ==========================================
// reset values
`define T1JA_RST_RDTH 8'h3F
`define T1JA_RST_RCTH 8'h7F
`define T1JA_RST_YTH 8'h0A
`define T1JA_RST_ATH 8'h3F
// ==========================================
// alarm bit positions
`define T1JA_B_RED 0
`define T1JA_B_YEL 1
`define T1JA_B_AIS 2
// ==========================================
// window timing, counted in received frames
`define T1JA_WIN_MS 40
`define T1JA_RCLR_MS 120
`define T1JA_FRAME_US 125
`define T1JA_WIN_FRAMES (`T1JA_WIN_MS * 1000 / `T1JA_FRAME_US)
// ==========================================
// per-window limits
`define T1JA_AIS_ZEROS 61
`define T1JA_SF_ONES 77
`define T1JA_ESF_PAT 16'hFF00
`define T1JA_ESF_HITS 7
`define T1JA_DM_ONES 4
`define T1JA_J1SF_ZEROS 4
`define T1JA_J1ESF_ZEROS 3
// ==========================================
// positions in the frame, all counted from 0
`define T1JA_SF_BIT 3'h1
`define T1JA_DM_BIT 3'h5
`define T1JA_DM_CH 5'h17
`define T1JA_J1_FRM 5'h0B
`endif

// File: t1ja_pkg.sv
// types shared by the alarm detector files
`default_nettype none
package t1ja_pkg;
  // framing formats, codes 6 and 7 unused
  typedef enum logic [2:0] {
    T1JA_SF = 3'h0,
    T1JA_ESF = 3'h1,
    T1JA_DM = 3'h2,
    T1JA_SLC = 3'h3,
    T1JA_J1SF = 3'h4,
    T1JA_J1ESF = 3'h5
  } t1ja_fmt_t;
  // one received bit with its frame position
  typedef struct packed {
    logic vld;
    logic dat;
    logic fbit;
    logic dl;
    logic frm_start;
    logic [4:0] ch;
    logic [2:0] bno;
    logic [4:0] frm;
  } t1ja_rx_t;
endpackage
`default_nettype wire

// File: t1ja_persist.sv
// persistence counter deciding one alarm per window
`default_nettype none
module t1ja_persist
  import t1ja_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // window verdicts
  input wire logic win_end,
  input wire logic eval_en,
  input wire logic decl_ok,
  input wire logic clr_ok,
  // persistence targets in windows
  input wire logic [9:0] decl_wins,
  input wire logic [9:0] clr_wins,
  // alarm state and change pulse
  output logic alarm_q,
  output logic flip
);
  logic alarm_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [9:0] tgt;
  logic ok;

  // a zero target still needs one window
  always_comb begin
    tgt = alarm_q ? clr_wins : decl_wins;
    if (tgt == 10'h000) begin
      tgt = 10'h001;
    end
    ok = alarm_q ? clr_ok : decl_ok;
  end

  always_comb begin
    alarm_d = alarm_q;
    cnt_d = cnt_q;
    if (win_end) begin
      if (!eval_en || !ok) begin
        cnt_d = 10'h000;
      end else if (cnt_q + 10'h001 >= tgt) begin
        alarm_d = !alarm_q;
        cnt_d = 10'h000;
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
    end
  end
  assign flip = alarm_d != alarm_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= 1'b0;
      cnt_q <= 10'h000;
    end else begin
      alarm_q <= alarm_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// File: t1ja_alarm_detector.sv
// receive-side t1/j1 alarm detector with apb registers
`default_nettype none
`include "t1ja_cfg.svh"

// ==========================================
// alarm detector top
module t1ja_alarm_detector
  import t1ja_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framed receive stream
  input wire t1ja_rx_t rx,
  input wire logic rx_in_sync,
  // interrupt, active low
  output logic alarm_irq_n
);
  localparam logic [8:0] win_last = 9'(`T1JA_WIN_FRAMES - 1);
  localparam logic [9:0] rclr_mul = 10'(`T1JA_RCLR_MS / `T1JA_WIN_MS);

  // ==========================================
  // helpers
  // apb word hit for a register index
  function automatic logic t1ja_hit(input logic [11:0] a,
                                    input logic [7:0] ix);
    t1ja_hit = a == {2'b00, ix, 2'b00};
  endfunction

  // saturating event count, restart at window edge
  function automatic logic [6:0] t1ja_next(input logic [6:0] c,
                                           input logic ev,
                                           input logic rst);
    logic [6:0] base;
    base = rst ? 7'h00 : c;
    t1ja_next = (ev && base != 7'h7F) ? base + 7'h01 : base;
  endfunction

  // ==========================================
  // declarations
  logic [8:0] frm_cnt_q;
  logic win_end;
  logic all_in_q;
  logic all_out_q;
  logic [6:0] zero_cnt_q;
  logic [6:0] yel_cnt_q;
  logic [15:0] dl_sr_q;
  logic zero_ev;
  logic yel_ev;
  logic yel_decl;
  logic ais_decl;
  logic esf_hit;
  t1ja_fmt_t fmt;
  logic [2:0] fmt_q;
  logic [2:0] ien_q;
  logic [2:0] chg_q;
  logic [2:0] chg_clr;
  logic [7:0] rdth_q;
  logic [7:0] rcth_q;
  logic [7:0] ydth_q;
  logic [7:0] ycth_q;
  logic [7:0] adth_q;
  logic [7:0] acth_q;
  logic [31:0] prdata_q;
  logic wr_ack;
  logic rd_setup;
  logic mapped;
  logic [2:0] alm;
  logic [2:0] flip;
  logic [2:0] eval_en;
  logic [2:0] decl_ok;
  logic [2:0] clr_ok;
  logic [2:0][9:0] decl_w;
  logic [2:0][9:0] clr_w;

  // ==========================================
  // window timing
  // window closes on frame start
  assign win_end = rx.frm_start && frm_cnt_q == win_last;

  // frame count within the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_cnt_q <= 9'h000;
    end else if (rx.frm_start) begin
      frm_cnt_q <= win_end ? 9'h000 : frm_cnt_q + 9'h001;
    end
  end

  // sync held through the whole window; first window after
  // reset is partial, so it never counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_in_q <= 1'b0;
      all_out_q <= 1'b0;
    end else if (win_end) begin
      all_in_q <= rx_in_sync;
      all_out_q <= !rx_in_sync;
    end else begin
      all_in_q <= all_in_q && rx_in_sync;
      all_out_q <= all_out_q && !rx_in_sync;
    end
  end

  // ==========================================
  // per-window event counts
  assign fmt = t1ja_fmt_t'(fmt_q);
  assign zero_ev = rx.vld && !rx.dat;
  assign esf_hit = rx.vld && rx.dl &&
    {dl_sr_q[14:0], rx.dat} == `T1JA_ESF_PAT;

  // link bit history, kept across windows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_sr_q <= 16'h0000;
    end else if (rx.vld && rx.dl) begin
      dl_sr_q <= {dl_sr_q[14:0], rx.dat};
    end
  end

  // yellow event by framing format
  always_comb begin
    yel_ev = 1'b0;
    unique case (fmt)
      // bit 2 ones of every channel
      T1JA_SF, T1JA_SLC: yel_ev = rx.vld && !rx.fbit &&
        rx.bno == `T1JA_SF_BIT && rx.dat;
      T1JA_ESF: yel_ev = esf_hit;
      T1JA_DM: yel_ev = rx.vld && !rx.fbit && rx.dat &&
        rx.ch == `T1JA_DM_CH && rx.bno == `T1JA_DM_BIT;
      T1JA_J1SF: yel_ev = rx.vld && rx.fbit && !rx.dat &&
        rx.frm == `T1JA_J1_FRM;
      T1JA_J1ESF: yel_ev = rx.vld && rx.dl && !rx.dat;
      default: yel_ev = rx.vld && !rx.fbit &&
        rx.bno == `T1JA_SF_BIT && rx.dat;
    endcase
  end

  // counters saturate; the edge cycle starts the next window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cnt_q <= 7'h00;
      yel_cnt_q <= 7'h00;
    end else begin
      zero_cnt_q <= t1ja_next(zero_cnt_q, zero_ev, win_end);
      yel_cnt_q <= t1ja_next(yel_cnt_q, yel_ev, win_end);
    end
  end

  // ==========================================
  // window verdicts
  // blue declare test
  assign ais_decl = zero_cnt_q < 7'(`T1JA_AIS_ZEROS);

  // yellow declare test; clearing is its complement
  always_comb begin
    unique case (fmt)
      T1JA_ESF: yel_decl = yel_cnt_q > 7'(`T1JA_ESF_HITS);
      T1JA_DM: yel_decl = yel_cnt_q < 7'(`T1JA_DM_ONES);
      T1JA_J1SF: yel_decl = yel_cnt_q < 7'(`T1JA_J1SF_ZEROS);
      T1JA_J1ESF: yel_decl = yel_cnt_q < 7'(`T1JA_J1ESF_ZEROS);
      T1JA_SF, T1JA_SLC: yel_decl = yel_cnt_q < 7'(`T1JA_SF_ONES);
      default: yel_decl = yel_cnt_q < 7'(`T1JA_SF_ONES);
    endcase
  end

  // verdicts and targets per alarm
  always_comb begin
    eval_en[`T1JA_B_RED] = 1'b1;
    decl_ok[`T1JA_B_RED] = all_out_q;
    // whole window in sync, three per step
    clr_ok[`T1JA_B_RED] = all_in_q;
    decl_w[`T1JA_B_RED] = {2'b00, rdth_q};
    clr_w[`T1JA_B_RED] = 10'({2'b00, rcth_q} * rclr_mul);
    eval_en[`T1JA_B_YEL] = all_in_q;
    decl_ok[`T1JA_B_YEL] = yel_decl;
    clr_ok[`T1JA_B_YEL] = !yel_decl;
    decl_w[`T1JA_B_YEL] = {2'b00, ydth_q};
    clr_w[`T1JA_B_YEL] = {2'b00, ycth_q};
    eval_en[`T1JA_B_AIS] = 1'b1;
    decl_ok[`T1JA_B_AIS] = ais_decl;
    clr_ok[`T1JA_B_AIS] = !ais_decl;
    decl_w[`T1JA_B_AIS] = {2'b00, adth_q};
    clr_w[`T1JA_B_AIS] = {2'b00, acth_q};
  end

  // one persistence counter per alarm
  for (genvar i = 0; i < 3; i++) begin : g_alm
    t1ja_persist u_persist (
      .pclk(pclk),
      .presetn(presetn),
      .win_end(win_end),
      .eval_en(eval_en[i]),
      .decl_ok(decl_ok[i]),
      .clr_ok(clr_ok[i]),
      .decl_wins(decl_w[i]),
      .clr_wins(clr_w[i]),
      .alarm_q(alm[i]),
      .flip(flip[i])
    );
  end

  // ==========================================
  // apb slave, no wait states
  assign pready = 1'b1;
  assign wr_ack = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = t1ja_hit(paddr, `T1JA_IX_STAT) ||
    t1ja_hit(paddr, `T1JA_IX_IEN) || t1ja_hit(paddr, `T1JA_IX_CHG) ||
    t1ja_hit(paddr, `T1JA_IX_RDTH) || t1ja_hit(paddr, `T1JA_IX_RCTH) ||
    t1ja_hit(paddr, `T1JA_IX_YDTH) || t1ja_hit(paddr, `T1JA_IX_YCTH) ||
    t1ja_hit(paddr, `T1JA_IX_ADTH) || t1ja_hit(paddr, `T1JA_IX_ACTH) ||
    t1ja_hit(paddr, `T1JA_IX_FMT);
  // unmapped words answer with an error, not silence
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= 3'h0;
      rdth_q <= `T1JA_RST_RDTH;
      rcth_q <= `T1JA_RST_RCTH;
      ydth_q <= `T1JA_RST_YTH;
      ycth_q <= `T1JA_RST_YTH;
      adth_q <= `T1JA_RST_ATH;
      acth_q <= `T1JA_RST_ATH;
      fmt_q <= 3'h0;
    end else if (wr_ack) begin
      if (t1ja_hit(paddr, `T1JA_IX_IEN)) ien_q <= pwdata[2:0];
      if (t1ja_hit(paddr, `T1JA_IX_RDTH)) rdth_q <= pwdata[7:0];
      if (t1ja_hit(paddr, `T1JA_IX_RCTH)) rcth_q <= pwdata[7:0];
      if (t1ja_hit(paddr, `T1JA_IX_YDTH)) ydth_q <= pwdata[7:0];
      if (t1ja_hit(paddr, `T1JA_IX_YCTH)) ycth_q <= pwdata[7:0];
      if (t1ja_hit(paddr, `T1JA_IX_ADTH)) adth_q <= pwdata[7:0];
      if (t1ja_hit(paddr, `T1JA_IX_ACTH)) acth_q <= pwdata[7:0];
      if (t1ja_hit(paddr, `T1JA_IX_FMT)) fmt_q <= pwdata[2:0];
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= 32'h0000_0000;
      if (t1ja_hit(paddr, `T1JA_IX_STAT)) prdata_q[2:0] <= alm;
      if (t1ja_hit(paddr, `T1JA_IX_IEN)) prdata_q[2:0] <= ien_q;
      if (t1ja_hit(paddr, `T1JA_IX_CHG)) prdata_q[2:0] <= chg_q;
      if (t1ja_hit(paddr, `T1JA_IX_RDTH)) prdata_q[7:0] <= rdth_q;
      if (t1ja_hit(paddr, `T1JA_IX_RCTH)) prdata_q[7:0] <= rcth_q;
      if (t1ja_hit(paddr, `T1JA_IX_YDTH)) prdata_q[7:0] <= ydth_q;
      if (t1ja_hit(paddr, `T1JA_IX_YCTH)) prdata_q[7:0] <= ycth_q;
      if (t1ja_hit(paddr, `T1JA_IX_ADTH)) prdata_q[7:0] <= adth_q;
      if (t1ja_hit(paddr, `T1JA_IX_ACTH)) prdata_q[7:0] <= acth_q;
      if (t1ja_hit(paddr, `T1JA_IX_FMT)) prdata_q[2:0] <= fmt_q;
    end
  end

  // ==========================================
  // change flags and interrupt
  assign chg_clr = (wr_ack && t1ja_hit(paddr, `T1JA_IX_CHG)) ?
    pwdata[2:0] : 3'h0;

  // set on either edge, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_q <= 3'h0;
    end else begin
      // write one clears, reads do not
      chg_q <= (chg_q & ~chg_clr) | flip;
    end
  end

  // enabled flags pull the pin low
  assign alarm_irq_n = !(|(chg_q & ien_q));

  // ==========================================
  // assertions
  default clocking t1ja_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_WIN_WRAP:
  assert property (win_end |=> frm_cnt_q == 9'h000 && !win_end)
    else $error("window count did not restart");

  // status moves only at window close
  AST_ALM_AT_WIN:
  assert property (alm != $past(alm) |-> $past(win_end))
    else $error("alarm changed between windows");

  AST_AIS_NO_SET:
  assert property (win_end && !alm[`T1JA_B_AIS] &&
    zero_cnt_q >= 7'h3D |=> !alm[`T1JA_B_AIS])
    else $error("blue alarm set with 61 zeros");

  AST_AIS_NO_CLR:
  assert property (win_end && alm[`T1JA_B_AIS] &&
    zero_cnt_q <= 7'h3C |=> alm[`T1JA_B_AIS])
    else $error("blue alarm cleared with 60 zeros");

  AST_YEL_SYNC:
  assert property (win_end && !all_in_q |=>
    alm[`T1JA_B_YEL] == $past(alm[`T1JA_B_YEL]))
    else $error("yellow changed outside sync");

  // partial sync loss never declares red
  AST_RED_SYNC:
  assert property (win_end && !alm[`T1JA_B_RED] && !all_out_q
    |=> !alm[`T1JA_B_RED])
    else $error("red declared without full loss");

  // every status edge raises its flag
  AST_CHG_SET:
  assert property (alm != $past(alm) |->
    (chg_q & (alm ^ $past(alm))) == (alm ^ $past(alm)))
    else $error("change flag missed an edge");

  // flag holds until a one is written
  AST_CHG_HOLD:
  assert property (chg_q != 3'h0 && chg_clr == 3'h0 |=>
    (chg_q & $past(chg_q)) == $past(chg_q))
    else $error("change flag dropped by itself");

  // write one clears when no new edge
  AST_CHG_CLR:
  assert property (chg_clr != 3'h0 && flip == 3'h0 |=>
    (chg_q & $past(chg_clr)) == 3'h0)
    else $error("change flag not cleared");

  // enabled flag drives the pin low
  AST_IRQ_ON:
  assert property (|(chg_q & ien_q) |-> !alarm_irq_n)
    else $error("interrupt missing");

  AST_IRQ_OFF:
  assert property ((chg_q & ien_q) == 3'h0 |-> alarm_irq_n)
    else $error("interrupt without enabled source");

  // main scenarios
  COV_AIS_RISE: cover property ($rose(alm[`T1JA_B_AIS]));
  COV_YEL_RISE: cover property ($rose(alm[`T1JA_B_YEL]));
  COV_RED_FALL: cover property ($fell(alm[`T1JA_B_RED]));
  COV_IRQ: cover property ($fell(alarm_irq_n));
endmodule
`default_nettype wire

// File: t1ja_rx_model.sv
// frame source model feeding the alarm detector receive side
`default_nettype none
module t1ja_rx_model
  import t1ja_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // window profile, taken at each window start
  input wire logic [2:0] fmt_i,
  input wire logic [8:0] hits_i,
  input wire logic sync_i,
  // framed stream and count of closed windows
  output var t1ja_rx_t rx,
  output logic rx_in_sync,
  output logic [7:0] closes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q;
  logic [8:0] pos_q;
  logic [8:0] cur_q;
  logic [2:0] fmt_q;
  logic [8:0] hits_q;
  logic hit;
  logic one;
  logic decoy;
  // first hits frames carry the marked value, esf sends ff00 per hit
  assign hit = (fmt_q == T1JA_ESF) ? ({4'h0, cur_q} < {hits_q, 4'h0})
                                   : (cur_q < hits_q);
  // in dm and j1sf, odd unmarked frames put the marked value on a wrong slot, so a
  // detector that ignores channel or frame number overcounts
  assign decoy = !hit && cur_q[0];
  assign one = (fmt_q == T1JA_ESF) ? (!hit || !cur_q[3]) :
               (fmt_q == T1JA_J1SF) ? (!hit && !cur_q[0]) :
               (fmt_q == T1JA_J1ESF) ? !hit :
               (fmt_q == T1JA_DM) ? (hit || cur_q[0]) : hit;
  // three cycles a frame: start, one bit, idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 2'h0;
      pos_q <= 9'h001;
      cur_q <= 9'h000;
      fmt_q <= 3'h0;
      hits_q <= 9'h000;
      rx <= '0;
      rx_in_sync <= 1'b0;
      closes <= 8'h00;
    end else begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      rx.frm_start <= (ph_q == 2'h0);
      rx.vld <= (ph_q == 2'h1);
      // idle data flips so a stale bit is never mistaken for a real one
      rx.dat <= (ph_q == 2'h1) ? one : ~rx.dat;
      rx.dl <= (fmt_q == T1JA_ESF) || (fmt_q == T1JA_J1ESF);
      rx.fbit <= (fmt_q == T1JA_J1SF);
      rx.frm <= (fmt_q == T1JA_J1SF && decoy) ? 5'h0A : 5'h0B;
      rx.ch <= (fmt_q == T1JA_DM) ? (decoy ? 5'h16 : 5'h17) :
               5'(cur_q % 9'h018);
      rx.bno <= (fmt_q == T1JA_DM) ? 3'h5 : 3'h1;
      if (ph_q == 2'h0) begin
        cur_q <= pos_q;
        pos_q <= (pos_q == 9'h13F) ? 9'h000 : pos_q + 9'h001;
        // sync changes with the window start, never inside a window
        if (pos_q == 9'h000) begin
          fmt_q <= fmt_i;
          hits_q <= hits_i;
          rx_in_sync <= sync_i;
          closes <= closes + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: t1ja_alarm_detector_test.sv
// self-checking bench for the alarm detector
`default_nettype none
`include "t1ja_cfg.svh"
module t1ja_alarm_detector_test
  import t1ja_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  t1ja_rx_t rx;
  logic rx_in_sync, alarm_irq_n, m_sync, err_q;
  logic [2:0] m_fmt;
  logic [8:0] m_hits;
  logic [7:0] closes;
  int n_fail, comparisons, seed;
  // ==========================================
  // design and far side
  t1ja_alarm_detector t1ja_alarm_detector_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx(rx), .rx_in_sync(rx_in_sync),
    .alarm_irq_n(alarm_irq_n));
  t1ja_rx_model t1ja_rx_model_inst (.pclk(pclk), .presetn(presetn),
    .fmt_i(m_fmt), .hits_i(m_hits), .sync_i(m_sync), .rx(rx),
    .rx_in_sync(rx_in_sync), .closes(closes));
  // ==========================================
  // helpers
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  // one transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] ix,
                     input logic [31:0] d);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (pready !== 1'b1 && w < 16);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      results();
    end
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] e,
                    input string nm);
    apb(1'b0, ix, $random(seed));
    chk(nm, e, rd_q);
  endtask
  task automatic bt(input logic [7:0] ix, input int b, input logic e,
                    input string nm);
    apb(1'b0, ix, 32'h0);
    chk(nm, {31'h0, e}, {31'h0, rd_q[b]});
  endtask
  // waits for n window closes, each under a bound
  task automatic wins(input int n);
    int w;
    logic [7:0] c;
    for (int k = 0; k < n; k++) begin
      c = closes;
      w = 0;
      while (closes === c && w < 2000) begin
        @(posedge pclk);
        w++;
      end
      if (closes === c) begin
        chk("window close", 32'h1, 32'h0);
        results();
      end
    end
    repeat (4) @(posedge pclk);
  endtask
  // new profile starts next window, so one extra close is waited for
  task automatic phase(input logic [2:0] f, input logic [8:0] h,
                       input logic s, input int n);
    @(posedge pclk);
    m_fmt <= f;
    m_hits <= h;
    m_sync <= s;
    wins(n + 1);
  endtask
  function automatic logic yel_exp(input logic [2:0] f, input logic [8:0] h);
    case (f)
      3'h1: return h > 9'h007;
      3'h2, 3'h4: return h < 9'h004;
      3'h5: return h < 9'h003;
      default: return h < 9'h04D;
    endcase
  endfunction
  // sf profile sends h ones, so 320 minus h zeros
  function automatic logic blue_exp(input logic [8:0] h);
    return (9'h140 - h) < 9'h03D;
  endfunction
  // ==========================================
  // clock and main sequence
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    logic [31:0] rv [9];
    logic [7:0] rw [8];
    logic [8:0] hd [6];
    logic [8:0] hc [6];
    logic [31:0] r;
    logic [8:0] h;
    rv = '{32'h0, 32'h0, 32'h0, 32'h3F, 32'h7F, 32'h0A, 32'h0A, 32'h3F,
           32'h3F};
    rw = '{8'hBA, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC1, 8'hC8};
    hd = '{9'h04C, 9'h008, 9'h003, 9'h04C, 9'h003, 9'h002};
    hc = '{9'h04D, 9'h007, 9'h004, 9'h04D, 9'h004, 9'h003};
    seed = 70356;
    n_fail = 0;
    comparisons = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {m_fmt, m_hits, m_sync} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(8'hB9 + 8'(i), rv[i], "reset value");
    end
    rd(`T1JA_IX_FMT, 32'h0, "format reset");
    chk("mapped error", 32'h0, {31'h0, err_q});
    rd(8'h00, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, {31'h0, err_q});
    apb(1'b1, `T1JA_IX_STAT, 32'hFF);
    rd(`T1JA_IX_STAT, 32'h0, "status write");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      apb(1'b1, rw[i % 8], r);
      rd(rw[i % 8], r & ((i % 8 == 0 || i % 8 == 7) ? 32'h7 : 32'hFF),
         "read back");
    end
    done("registers");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'hBC + 8'(i), (i == 0) ? 32'h2 : 32'h1);
    end
    apb(1'b1, `T1JA_IX_FMT, 32'h0);
    apb(1'b1, `T1JA_IX_IEN, 32'h1);
    apb(1'b1, `T1JA_IX_CHG, 32'h7);
    wins(2);
    bt(`T1JA_IX_STAT, `T1JA_B_RED, 1'b0, "red early");
    wins(1);
    bt(`T1JA_IX_STAT, `T1JA_B_RED, 1'b1, "red declared");
    bt(`T1JA_IX_STAT, `T1JA_B_YEL, 1'b0, "yellow unsynced");
    rd(`T1JA_IX_CHG, 32'h1, "red changed");
    chk("irq on", 32'h0, {31'h0, alarm_irq_n});
    apb(1'b1, `T1JA_IX_IEN, 32'h0);
    rd(`T1JA_IX_IEN, 32'h0, "enable off");
    chk("irq masked", 32'h1, {31'h0, alarm_irq_n});
    apb(1'b1, `T1JA_IX_IEN, 32'h1);
    apb(1'b1, `T1JA_IX_CHG, 32'h6);
    rd(`T1JA_IX_CHG, 32'h1, "flag kept");
    rd(`T1JA_IX_CHG, 32'h1, "flag after read");
    chk("irq again", 32'h0, {31'h0, alarm_irq_n});
    apb(1'b1, `T1JA_IX_CHG, 32'h1);
    rd(`T1JA_IX_CHG, 32'h0, "flag cleared");
    chk("irq off", 32'h1, {31'h0, alarm_irq_n});
    done("red declare");
    phase(3'h0, 9'h000, 1'b1, 2);
    bt(`T1JA_IX_STAT, `T1JA_B_RED, 1'b1, "red held");
    wins(1);
    bt(`T1JA_IX_STAT, `T1JA_B_RED, 1'b0, "red cleared");
    bt(`T1JA_IX_CHG, `T1JA_B_RED, 1'b1, "red fall flag");
    done("red clear");
    for (int i = 0; i < 3; i++) begin
      h = (i == 1) ? 9'h104 : 9'h103;
      phase(3'h0, h, 1'b1, 1);
      bt(`T1JA_IX_STAT, `T1JA_B_AIS, blue_exp(h), "blue");
    end
    bt(`T1JA_IX_CHG, `T1JA_B_AIS, 1'b1, "blue flag");
    done("blue");
    for (int f = 0; f < 6; f++) begin
      apb(1'b1, `T1JA_IX_FMT, 32'(f));
      for (int j = 0; j < 2; j++) begin
        h = (j == 1) ? hc[f] : hd[f];
        phase(3'(f), h, 1'b1, 1);
        bt(`T1JA_IX_STAT, `T1JA_B_YEL, yel_exp(3'(f), h), "yellow");
      end
    end
    // unused format code judges as sf
    apb(1'b1, `T1JA_IX_FMT, 32'h6);
    phase(3'h0, 9'h04C, 1'b1, 1);
    bt(`T1JA_IX_STAT, `T1JA_B_YEL, 1'b1, "yellow code 6");
    done("yellow");
    results();
  end
endmodule
`default_nettype wire
